// ==== iem_pkg.sv ====
// Constants for the interrupt enable masking block: register addresses,
// bit positions, reset values and source indices.
// Assumes an 8-bit special-function register bus with bit addressing.
`default_nettype none
package iem_pkg;
   localparam int         IEM_REG_W        = 8;
   localparam logic [7:0] IEM_MAIN_ADDR    = 8'hA8;
   localparam logic [7:0] IEM_EXT1_ADDR    = 8'hE6;
   localparam logic [7:0] IEM_RESET_VAL    = 8'h00;
   localparam logic [7:0] IEM_UNMAPPED_RD  = 8'h00;
   // Upper five bits of the bit address that lands on the main register
   localparam logic [4:0] IEM_MAIN_BIT_BASE = 5'h15;

   // Main mask register bit positions
   localparam int IEM_B_GLOBAL     = 7;
   localparam int IEM_B_SERIAL     = 6;
   localparam int IEM_B_TIMER2     = 5;
   localparam int IEM_B_ASYNC      = 4;
   localparam int IEM_B_TIMER1     = 3;
   localparam int IEM_B_EXT1       = 2;
   localparam int IEM_B_TIMER0     = 1;
   localparam int IEM_B_EXT0       = 0;
   // Extended mask register bit positions
   localparam int IEM_B_LIN        = 7;
   localparam int IEM_B_TIMER3     = 6;
   localparam int IEM_B_COMP1      = 5;
   localparam int IEM_B_COMP0      = 4;
   localparam int IEM_B_COUNTER    = 3;
   localparam int IEM_B_CONV       = 2;
   localparam int IEM_B_WINDOW     = 1;
   localparam int IEM_B_TWO_WIRE   = 0;

   // Request vector: main sources at their bit, extended ones above them
   localparam int IEM_NSRC         = 15;
   localparam int IEM_EXT_OFS      = 7;
endpackage
`default_nettype wire

// ==== iem_top.sv ====
// Interrupt enable masking: main and first extended mask registers and
// the per-source gating of pending flags toward the core.
// Assumes pending flags come from same-clock logic; external inputs are
// already polarity-corrected but asynchronous, so they are synchronised.
//
// What this block does
// (RULE1) Global enable bit 7 overrides all masks; zero blocks every source.
// (RULE2) Main bit 6 gates all serial peripheral unit requests.
// (RULE3) Main bit 5 passes timer two low or high overflow requests.
// (RULE4) Main bit 4 masks the asynchronous serial port interrupt.
// (RULE5) Main bit 3 passes timer one overflow requests.
// (RULE6) Main bit 2 passes external input one requests.
// (RULE7) Main bit 1 passes timer zero overflow requests.
// (RULE8) Main bit 0 passes external input zero requests.
// (RULE9) Extended bit 7 passes the LIN unit interrupt flag.
// (RULE10) Extended bit 6 passes timer three low or high overflow requests.
// (RULE11) Extended bit 5 passes comparator one rise or fall flags.
// (RULE12) Extended bit 4 passes comparator zero rise or fall flags.
// (RULE13) Extended bit 3 gates all counter array requests.
// (RULE14) Extended bit 2 passes the conversion complete flag.
// (RULE15) Extended bit 1 passes the window comparison flag.
// (RULE16) Extended bit 0 gates all two-wire bus unit requests.
// (RULE17) Main register sits at 0xA8 on every page, bit addressable.
// (RULE18) Extended register sits at 0xE6 on every page.
// (RULE19) Each request is flags AND own mask AND global, every clock.
// (RULE20) All mask bits read and write, and clear to zero on reset.
`timescale 1ns/1ps
`default_nettype none
module iem_top
   import iem_pkg::*;
(
   input  wire logic                 sys_clk,
   input  wire logic                 rst,
   input  wire logic [7:0]           sfr_addr,
   input  wire logic                 sfr_wr,
   input  wire logic [IEM_REG_W-1:0] sfr_wdata,
   input  wire logic                 sfr_rd,
   output logic      [IEM_REG_W-1:0] sfr_rdata,
   input  wire logic [7:0]           sfr_bit_addr,
   input  wire logic                 sfr_bit_wr,
   input  wire logic                 sfr_bit_wval,
   input  wire logic                 sfr_bit_rd,
   output logic                      sfr_bit_rdata,
   input  wire logic                 serial_periph_unit_req,
   input  wire logic                 timer_two_low_overflow_flag,
   input  wire logic                 timer_two_high_overflow_flag,
   input  wire logic                 async_serial_unit_req,
   input  wire logic                 timer_one_overflow_flag,
   input  wire logic                 ext_irq_input_one,
   input  wire logic                 timer_zero_overflow_flag,
   input  wire logic                 ext_irq_input_zero,
   input  wire logic                 lin_unit_irq_flag,
   input  wire logic                 timer_three_low_overflow_flag,
   input  wire logic                 timer_three_high_overflow_flag,
   input  wire logic                 comparator_one_rise_flag,
   input  wire logic                 comparator_one_fall_flag,
   input  wire logic                 comparator_zero_rise_flag,
   input  wire logic                 comparator_zero_fall_flag,
   input  wire logic                 programmable_counter_array_req,
   input  wire logic                 conversion_done_flag,
   input  wire logic                 window_compare_flag,
   input  wire logic                 two_wire_bus_unit_req,
   output logic                      serial_periph_irq,
   output logic                      timer_two_irq,
   output logic                      async_serial_irq,
   output logic                      timer_one_irq,
   output logic                      ext_input_one_irq,
   output logic                      timer_zero_irq,
   output logic                      ext_input_zero_irq,
   output logic                      lin_unit_irq,
   output logic                      timer_three_irq,
   output logic                      comparator_one_irq,
   output logic                      comparator_zero_irq,
   output logic                      counter_array_irq,
   output logic                      conversion_done_irq,
   output logic                      window_compare_irq,
   output logic                      two_wire_bus_irq
);

   logic [IEM_REG_W-1:0] main_q;
   logic [IEM_REG_W-1:0] ext1_q;
   logic [1:0]           ext_meta_q;
   logic [1:0]           ext_sync_q;
   logic [IEM_NSRC-1:0]  pend;
   logic [IEM_NSRC-1:0]  gate;
   logic [IEM_NSRC-1:0]  req_d;
   logic [IEM_NSRC-1:0]  req_q;
   logic                 main_sel;
   logic                 ext1_sel;
   logic                 bit_sel;
   logic [2:0]           bit_idx;

   // Register page is not decoded: both registers answer on every page
   assign main_sel = (sfr_addr == IEM_MAIN_ADDR); // RULE17
   assign ext1_sel = (sfr_addr == IEM_EXT1_ADDR); // RULE18
   assign bit_sel  = (sfr_bit_addr[7:3] == IEM_MAIN_BIT_BASE); // RULE17
   assign bit_idx  = sfr_bit_addr[2:0];

   // Byte write wins over a bit write landing in the same cycle
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         main_q <= IEM_RESET_VAL; // RULE20
      end else if (sfr_wr && main_sel) begin
         main_q <= sfr_wdata; // RULE17
      end else if (sfr_bit_wr && bit_sel) begin
         main_q[bit_idx] <= sfr_bit_wval; // RULE17
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ext1_q <= IEM_RESET_VAL; // RULE20
      end else if (sfr_wr && ext1_sel) begin
         ext1_q <= sfr_wdata; // RULE18
      end
   end

   // Unmapped addresses read as zero so the core sees a defined value
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sfr_rdata <= IEM_UNMAPPED_RD;
      end else if (sfr_rd) begin
         if (main_sel) begin
            sfr_rdata <= main_q; // RULE20
         end else if (ext1_sel) begin
            sfr_rdata <= ext1_q; // RULE20
         end else begin
            sfr_rdata <= IEM_UNMAPPED_RD;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sfr_bit_rdata <= 1'b0;
      end else if (sfr_bit_rd) begin
         sfr_bit_rdata <= bit_sel && main_q[bit_idx]; // RULE17
      end
   end

   // External inputs are pins: two flops before any gating
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ext_meta_q <= 2'h0;
         ext_sync_q <= 2'h0;
      end else begin
         ext_meta_q <= {ext_irq_input_one, ext_irq_input_zero};
         ext_sync_q <= ext_meta_q;
      end
   end

   always_comb begin
      pend = '0;
      pend[IEM_B_SERIAL] = serial_periph_unit_req; // RULE2
      pend[IEM_B_TIMER2] = timer_two_low_overflow_flag
                         | timer_two_high_overflow_flag; // RULE3
      pend[IEM_B_ASYNC]  = async_serial_unit_req; // RULE4
      pend[IEM_B_TIMER1] = timer_one_overflow_flag; // RULE5
      pend[IEM_B_EXT1]   = ext_sync_q[1]; // RULE6
      pend[IEM_B_TIMER0] = timer_zero_overflow_flag; // RULE7
      pend[IEM_B_EXT0]   = ext_sync_q[0]; // RULE8
      pend[IEM_EXT_OFS + IEM_B_LIN] = lin_unit_irq_flag; // RULE9
      pend[IEM_EXT_OFS + IEM_B_TIMER3] = timer_three_low_overflow_flag
                         | timer_three_high_overflow_flag; // RULE10
      pend[IEM_EXT_OFS + IEM_B_COMP1] = comparator_one_rise_flag
                         | comparator_one_fall_flag; // RULE11
      pend[IEM_EXT_OFS + IEM_B_COMP0] = comparator_zero_rise_flag
                         | comparator_zero_fall_flag; // RULE12
      pend[IEM_EXT_OFS + IEM_B_COUNTER] =
         programmable_counter_array_req; // RULE13
      pend[IEM_EXT_OFS + IEM_B_CONV] = conversion_done_flag; // RULE14
      pend[IEM_EXT_OFS + IEM_B_WINDOW] = window_compare_flag; // RULE15
      pend[IEM_EXT_OFS + IEM_B_TWO_WIRE] = two_wire_bus_unit_req; // RULE16
   end

   // Individual masks line up with the pending vector; bit 7 of main
   // is not a source mask and is left out of this vector
   assign gate  = {ext1_q, main_q[IEM_B_SERIAL:0]};
   assign req_d = pend & gate & {IEM_NSRC{main_q[IEM_B_GLOBAL]}}; // RULE1

   // Registered so the core sees a glitch-free level, one cycle late
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         req_q <= '0;
      end else begin
         req_q <= req_d; // RULE19
      end
   end

   assign serial_periph_irq   = req_q[IEM_B_SERIAL];
   assign timer_two_irq       = req_q[IEM_B_TIMER2];
   assign async_serial_irq    = req_q[IEM_B_ASYNC];
   assign timer_one_irq       = req_q[IEM_B_TIMER1];
   assign ext_input_one_irq   = req_q[IEM_B_EXT1];
   assign timer_zero_irq      = req_q[IEM_B_TIMER0];
   assign ext_input_zero_irq  = req_q[IEM_B_EXT0];
   assign lin_unit_irq        = req_q[IEM_EXT_OFS + IEM_B_LIN];
   assign timer_three_irq     = req_q[IEM_EXT_OFS + IEM_B_TIMER3];
   assign comparator_one_irq  = req_q[IEM_EXT_OFS + IEM_B_COMP1];
   assign comparator_zero_irq = req_q[IEM_EXT_OFS + IEM_B_COMP0];
   assign counter_array_irq   = req_q[IEM_EXT_OFS + IEM_B_COUNTER];
   assign conversion_done_irq = req_q[IEM_EXT_OFS + IEM_B_CONV];
   assign window_compare_irq  = req_q[IEM_EXT_OFS + IEM_B_WINDOW];
   assign two_wire_bus_irq    = req_q[IEM_EXT_OFS + IEM_B_TWO_WIRE];

   default clocking iem_cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   sequence s_main_write;
      sfr_wr && main_sel;
   endsequence

   sequence s_main_read_back;
      sfr_rd && main_sel && !sfr_wr && !sfr_bit_wr;
   endsequence

   sequence s_ext1_write;
      sfr_wr && ext1_sel;
   endsequence

   sequence s_ext1_read_back;
      sfr_rd && ext1_sel && !sfr_wr;
   endsequence

   AST_GLOBAL_OFF: assert property ( // RULE1
      !main_q[IEM_B_GLOBAL] |=> (req_q == '0))
      else $error("request raised while global enable was clear");

   AST_SERIAL_GATE: assert property ( // RULE2
      !main_q[IEM_B_SERIAL] |=> !serial_periph_irq)
      else $error("serial peripheral request passed while masked");

   AST_TIMER2_PASS: assert property ( // RULE3
      (main_q[IEM_B_GLOBAL] && main_q[IEM_B_TIMER2]
       && timer_two_high_overflow_flag) |=> timer_two_irq)
      else $error("timer two high overflow not passed");

   AST_ASYNC_GATE: assert property ( // RULE4
      async_serial_irq |-> $past(main_q[IEM_B_ASYNC]
                                 && async_serial_unit_req))
      else $error("async serial request without mask and flag");

   AST_TIMER1_PASS: assert property ( // RULE5
      timer_one_irq == $past(main_q[IEM_B_GLOBAL] && main_q[IEM_B_TIMER1]
                             && timer_one_overflow_flag))
      else $error("timer one request does not follow flag and mask");

   // Watches the second flop only; the first may still be metastable
   AST_EXT1_LATENCY: assert property ( // RULE6
      (main_q[IEM_B_GLOBAL] && main_q[IEM_B_EXT1])[*3]
      ##0 $rose(ext_sync_q[1]) |=> ext_input_one_irq)
      else $error("external input one not passed one cycle after sync");

   AST_TIMER0_GATE: assert property ( // RULE7
      timer_zero_irq |-> $past(main_q[IEM_B_TIMER0], 1))
      else $error("timer zero request passed while masked");

   AST_EXT0_GATE: assert property ( // RULE8
      ext_input_zero_irq == $past(main_q[IEM_B_GLOBAL]
                                  && main_q[IEM_B_EXT0] && ext_sync_q[0]))
      else $error("external input zero request mismatch");

   AST_LIN_PASS: assert property ( // RULE9
      lin_unit_irq == $past(main_q[IEM_B_GLOBAL] && ext1_q[IEM_B_LIN]
                            && lin_unit_irq_flag))
      else $error("lin unit request mismatch");

   AST_TIMER3_PASS: assert property ( // RULE10
      (main_q[IEM_B_GLOBAL] && ext1_q[IEM_B_TIMER3]
       && timer_three_low_overflow_flag) |=> timer_three_irq)
      else $error("timer three low overflow not passed");

   AST_COMP1_PASS: assert property ( // RULE11
      (main_q[IEM_B_GLOBAL] && ext1_q[IEM_B_COMP1]
       && comparator_one_fall_flag) |=> comparator_one_irq)
      else $error("comparator one fall flag not passed");

   AST_COMP0_GATE: assert property ( // RULE12
      comparator_zero_irq |-> $past(ext1_q[IEM_B_COMP0]
         && (comparator_zero_rise_flag || comparator_zero_fall_flag)))
      else $error("comparator zero request without mask and flag");

   AST_COUNTER_GATE: assert property ( // RULE13
      !ext1_q[IEM_B_COUNTER] |=> !counter_array_irq)
      else $error("counter array request passed while masked");

   AST_CONV_PASS: assert property ( // RULE14
      conversion_done_irq == $past(main_q[IEM_B_GLOBAL]
                         && ext1_q[IEM_B_CONV] && conversion_done_flag))
      else $error("conversion done request mismatch");

   AST_WINDOW_GATE: assert property ( // RULE15
      !ext1_q[IEM_B_WINDOW] |=> !window_compare_irq)
      else $error("window compare request passed while masked");

   AST_TWO_WIRE_PASS: assert property ( // RULE16
      two_wire_bus_irq == $past(main_q[IEM_B_GLOBAL]
                         && ext1_q[IEM_B_TWO_WIRE] && two_wire_bus_unit_req))
      else $error("two-wire bus request mismatch");

   AST_MAIN_READBACK: assert property ( // RULE17
      s_main_write ##1 s_main_read_back |=>
         (sfr_rdata == $past(sfr_wdata, 2)))
      else $error("main register read back differs from written byte");

   AST_BIT_WRITE: assert property ( // RULE17
      (sfr_bit_wr && bit_sel && !(sfr_wr && main_sel)) |=>
         (main_q[$past(bit_idx)] == $past(sfr_bit_wval)))
      else $error("bit write did not land in main register");

   AST_EXT1_READBACK: assert property ( // RULE18
      s_ext1_write ##1 s_ext1_read_back |=>
         (sfr_rdata == $past(sfr_wdata, 2)))
      else $error("extended register read back differs");

   AST_REQ_AND: assert property ( // RULE19
      req_q == $past(pend & gate & {IEM_NSRC{main_q[IEM_B_GLOBAL]}}))
      else $error("request vector is not flags and masks");

   AST_RESET_CLEAR: assert property ( // RULE20
      $fell(rst) |-> (main_q == IEM_RESET_VAL) && (ext1_q == IEM_RESET_VAL)
                     && (req_q == '0))
      else $error("mask registers or requests not clear after reset");

   AST_SERIAL_PASS: assert property ( // RULE2
      (main_q[IEM_B_GLOBAL] && main_q[IEM_B_SERIAL]
       && serial_periph_unit_req) |=> serial_periph_irq)
      else $error("serial peripheral request not passed");

   // Unmapped reads must not leak either register onto the bus
   AST_UNMAPPED_READ: assert property ( // RULE18
      (sfr_rd && !main_sel && !ext1_sel) |=> (sfr_rdata == IEM_UNMAPPED_RD))
      else $error("unmapped read returned a nonzero byte");

   // No bit access to the extended register
   AST_EXT1_NO_BIT: assert property ( // RULE18
      (sfr_bit_wr && !sfr_wr) |=> $stable(ext1_q))
      else $error("bit write disturbed the extended register");

   AST_BIT_READ_OUT: assert property ( // RULE17
      (sfr_bit_rd && !bit_sel) |=> !sfr_bit_rdata)
      else $error("bit read outside the main register returned one");

endmodule
`default_nettype wire

// ==== iem_core_model.sv ====
// Core-side partner: keeps a sticky record of the requests it has seen.
// Assumes request lines are registered levels in the sys_clk domain.
`timescale 1ns/1ps
`default_nettype none
module iem_core_model (
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        clr,
   input  wire logic [14:0] req,
   output logic      [14:0] seen_q
);
   // Sticky, so a one-cycle glitch on a request is missed only in a cycle with rst or clr high
   always_ff @(posedge sys_clk) begin
      if (rst || clr) begin
         seen_q <= 15'h0000;
      end else begin
         seen_q <= seen_q | req;
      end
   end
endmodule
`default_nettype wire

// ==== interrupt_enable_masking_tb.sv ====
// Self-checking bench for the interrupt enable masking block.
// Assumes iem_pkg, iem_top and iem_core_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module interrupt_enable_masking_tb
   import iem_pkg::*;
;
   typedef struct packed {
      logic [7:0]  m;
      logic [7:0]  e;
      logic [18:0] f;
      logic [14:0] q;
   } iem_row_t;
   localparam iem_row_t rows [12] = '{
      '{8'h00, 8'hFF, 19'h7FFFF, 15'h0000},
      '{8'h7F, 8'hFF, 19'h7FFFF, 15'h0000},
      '{8'hFF, 8'hFF, 19'h7FFFF, 15'h7FFF},
      '{8'hFF, 8'h00, 19'h7FFFF, 15'h007F},
      '{8'h80, 8'hFF, 19'h7FFFF, 15'h7F80},
      '{8'hAA, 8'h55, 19'h7FFFF, 15'h2AAA},
      '{8'hD5, 8'hAA, 19'h7FFFF, 15'h5555},
      '{8'hFF, 8'hFF, 19'h15020, 15'h3820},
      '{8'hFF, 8'hFF, 19'h2A040, 15'h3820},
      '{8'hFF, 8'hFF, 19'h55555, 15'h7AB5},
      '{8'hFF, 8'hFF, 19'h2AAAA, 15'h3D6A},
      '{8'hFF, 8'hFF, 19'h00000, 15'h0000}};
   logic        sys_clk;
   logic        rst;
   logic [7:0]  sfr_addr;
   logic        sfr_wr;
   logic [7:0]  sfr_wdata;
   logic        sfr_rd;
   logic [7:0]  sfr_rdata;
   logic [7:0]  sfr_bit_addr;
   logic        sfr_bit_wr;
   logic        sfr_bit_wval;
   logic        sfr_bit_rd;
   logic        sfr_bit_rdata;
   logic [18:0] fl;
   logic        clr;
   wire  logic [14:0] irq;
   logic [14:0] seen;
   int          errors;
   int          checks;
   logic [7:0]  d;
   logic        b;

   iem_top dut (
      .sys_clk(sys_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
      .sfr_bit_addr(sfr_bit_addr), .sfr_bit_wr(sfr_bit_wr),
      .sfr_bit_wval(sfr_bit_wval), .sfr_bit_rd(sfr_bit_rd),
      .sfr_bit_rdata(sfr_bit_rdata),
      .ext_irq_input_zero(fl[0]), .timer_zero_overflow_flag(fl[1]),
      .ext_irq_input_one(fl[2]), .timer_one_overflow_flag(fl[3]),
      .async_serial_unit_req(fl[4]), .timer_two_low_overflow_flag(fl[5]),
      .timer_two_high_overflow_flag(fl[6]), .serial_periph_unit_req(fl[7]),
      .two_wire_bus_unit_req(fl[8]), .window_compare_flag(fl[9]),
      .conversion_done_flag(fl[10]),
      .programmable_counter_array_req(fl[11]),
      .comparator_zero_rise_flag(fl[12]), .comparator_zero_fall_flag(fl[13]),
      .comparator_one_rise_flag(fl[14]), .comparator_one_fall_flag(fl[15]),
      .timer_three_low_overflow_flag(fl[16]),
      .timer_three_high_overflow_flag(fl[17]), .lin_unit_irq_flag(fl[18]),
      .ext_input_zero_irq(irq[0]), .timer_zero_irq(irq[1]),
      .ext_input_one_irq(irq[2]), .timer_one_irq(irq[3]),
      .async_serial_irq(irq[4]), .timer_two_irq(irq[5]),
      .serial_periph_irq(irq[6]), .two_wire_bus_irq(irq[7]),
      .window_compare_irq(irq[8]), .conversion_done_irq(irq[9]),
      .counter_array_irq(irq[10]), .comparator_zero_irq(irq[11]),
      .comparator_one_irq(irq[12]), .timer_three_irq(irq[13]),
      .lin_unit_irq(irq[14]));

   iem_core_model core (
      .sys_clk(sys_clk), .rst(rst), .clr(clr), .req(irq), .seen_q(seen));

   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   task chk(input logic [18:0] s, input logic [18:0] e);
      checks = checks + 1;
      if (s !== e) begin
         errors = errors + 1;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask

   task run(input int n);
      repeat (n) @(negedge sys_clk);
   endtask

   task wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge sys_clk);
      sfr_addr = a;
      sfr_wdata = v;
      sfr_wr = 1'b1;
      @(negedge sys_clk);
      sfr_wr = 1'b0;
   endtask

   task rd(input logic [7:0] a, output logic [7:0] v);
      @(negedge sys_clk);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(negedge sys_clk);
      sfr_rd = 1'b0;
      v = sfr_rdata;
   endtask

   // Write then read strobed in the very next cycle
   task wrd(input logic [7:0] a, input logic [7:0] v, output logic [7:0] r);
      @(negedge sys_clk);
      sfr_addr = a;
      sfr_wdata = v;
      sfr_wr = 1'b1;
      @(negedge sys_clk);
      sfr_wr = 1'b0;
      sfr_rd = 1'b1;
      @(negedge sys_clk);
      sfr_rd = 1'b0;
      r = sfr_rdata;
   endtask

   task bwr(input logic [7:0] a, input logic v);
      @(negedge sys_clk);
      sfr_bit_addr = a;
      sfr_bit_wval = v;
      sfr_bit_wr = 1'b1;
      @(negedge sys_clk);
      sfr_bit_wr = 1'b0;
   endtask

   task brd(input logic [7:0] a, output logic v);
      @(negedge sys_clk);
      sfr_bit_addr = a;
      sfr_bit_rd = 1'b1;
      @(negedge sys_clk);
      sfr_bit_rd = 1'b0;
      v = sfr_bit_rdata;
   endtask

   task finish_test;
      $display("checks=%0d errors=%0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Whole run is a few hundred cycles; this leaves wide margin
   initial begin
      #20000;
      errors = errors + 1;
      $display("test watchdog expired");
      finish_test;
   end

   initial begin
      errors = 0;
      checks = 0;
      rst = 1'b1;
      sfr_addr = 8'h00;
      sfr_wr = 1'b0;
      sfr_wdata = 8'h00;
      sfr_rd = 1'b0;
      sfr_bit_addr = 8'h00;
      sfr_bit_wr = 1'b0;
      sfr_bit_wval = 1'b0;
      sfr_bit_rd = 1'b0;
      fl = 19'h00000;
      clr = 1'b0;
      run(2);
      rst = 1'b0;
      chk(irq, 19'h00000);
      rd(IEM_MAIN_ADDR, d);
      chk(d, IEM_RESET_VAL);
      rd(IEM_EXT1_ADDR, d);
      chk(d, IEM_RESET_VAL);
      $display("test reset done");
      foreach (rows[i]) begin
         wr(IEM_MAIN_ADDR, rows[i].m);
         wr(IEM_EXT1_ADDR, rows[i].e);
         rd(IEM_MAIN_ADDR, d);
         chk(d, rows[i].m);
         rd(IEM_EXT1_ADDR, d);
         chk(d, rows[i].e);
         // Four cycles cover the two-flop path of the external inputs
         fl = rows[i].f;
         run(4);
         chk(irq, rows[i].q);
         chk(irq[0], rows[i].q[0]);
         clr = 1'b1;
         run(1);
         clr = 1'b0;
         run(1);
         chk(seen, rows[i].q);
         chk(seen[9:7], rows[i].q[9:7]);
      end
      $display("test table done");
      wr(IEM_MAIN_ADDR, 8'h00);
      for (int i = 0; i < 8; i++) begin
         bwr(IEM_MAIN_ADDR + 8'(i), 1'b1);
         brd(IEM_MAIN_ADDR + 8'(i), b);
         chk(b, 1'b1);
      end
      rd(IEM_MAIN_ADDR, d);
      chk(d, 8'hFF);
      brd(8'hB0, b);
      chk(b, 1'b0);
      $display("test bit access done");
      wr(IEM_MAIN_ADDR, 8'h82);
      fl = 19'h00002;
      chk(irq, 19'h00000);
      run(1);
      chk(irq, 19'h00002);
      fl = 19'h00000;
      run(1);
      chk(irq, 19'h00000);
      fl = 19'h00002;
      bwr(IEM_MAIN_ADDR + 8'h07, 1'b0);
      run(1);
      chk(irq, 19'h00000);
      fl = 19'h00000;
      $display("test latency done");
      wr(8'hE5, 8'hFF);
      rd(8'hE5, d);
      chk(d, IEM_UNMAPPED_RD);
      wrd(IEM_MAIN_ADDR, 8'h5A, d);
      chk(d, 8'h5A);
      wrd(IEM_EXT1_ADDR, 8'hA5, d);
      chk(d, 8'hA5);
      // Byte and bit write to the same register in one cycle
      @(negedge sys_clk);
      sfr_addr = IEM_MAIN_ADDR;
      sfr_wdata = 8'h00;
      sfr_wr = 1'b1;
      sfr_bit_addr = IEM_MAIN_ADDR;
      sfr_bit_wval = 1'b1;
      sfr_bit_wr = 1'b1;
      @(negedge sys_clk);
      sfr_wr = 1'b0;
      sfr_bit_wr = 1'b0;
      rd(IEM_MAIN_ADDR, d);
      chk(d, 8'h00);
      wr(IEM_EXT1_ADDR, 8'hFF);
      rst = 1'b1;
      run(2);
      rst = 1'b0;
      rd(IEM_EXT1_ADDR, d);
      chk(d, IEM_RESET_VAL);
      $display("test odd cases done");
      finish_test;
   end
endmodule
`default_nettype wire
